// ### cbd_core.v
// Branch and data-transfer execution core with an APB register port.
// Assumes data memory and program memory answer reads within the
// operation's length, the I/O space answers in the same cycle, and
// program-memory writes signal completion with a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
`include "cbd_map.vh"

// What this block does
// - Branch to pc plus offset plus one when user flag is zero.
// - Branch to pc plus offset plus one when signed carry is one.
// - Branch to pc plus offset plus one when signed carry is zero.
// - Branch to pc plus offset plus one when mask enable is one.
// - Branch to pc plus offset plus one when mask enable is zero.
// - Indirect post-increment load reads pointed byte then bumps pointer; two cycles.
// - Indirect pre-decrement load lowers pointer first then reads; two cycles.
// - Displaced load reads pointer plus displacement, pointer kept; two cycles.
// - Direct load reads the constant address; two cycles.
// - Indirect post-increment store writes then bumps pointer; two cycles.
// - Indirect pre-decrement store lowers pointer then writes; two cycles.
// - Displaced store writes pointer plus displacement, pointer kept; two cycles.
// - Direct store writes the constant address; two cycles.
// - Program read loads byte at third pointer, optional increment; three cycles.
// - Push and pop each take two cycles, flags untouched.
// - Pop returns the most recently pushed byte.
module cbd_core (
	input wire i_clk, // System clock
	input wire i_rst_n, // Async reset, active low
	input wire i_psel, // APB select
	input wire i_penable, // APB enable
	input wire i_pwrite, // APB direction
	input wire [11:0] i_paddr, // APB byte address
	input wire [31:0] i_pwdata, // APB write data
	output reg o_pready, // APB ready
	output reg [31:0] o_prdata, // APB read data
	output reg o_pslverr, // APB error
	output reg o_busy, // Operation in progress
	output reg [15:0] o_dm_addr, // Data memory address
	output reg o_dm_re, // Data memory read, held
	output reg o_dm_we, // Data memory write pulse
	output reg [7:0] o_dm_wdata, // Data memory write byte
	input wire [7:0] i_dm_rdata, // Data memory read byte
	output reg [15:0] o_pm_addr, // Program memory byte address
	output reg o_pm_re, // Program memory read, held
	output reg o_pm_we, // Program memory write pulse
	output reg [15:0] o_pm_wdata, // Program memory write word
	input wire [7:0] i_pm_rdata, // Program memory read byte
	input wire i_pm_done, // Program write finished
	output reg [5:0] o_io_addr, // Port address
	output reg o_io_re, // Port read, held
	output reg o_io_we, // Port write pulse
	output reg [7:0] o_io_wdata, // Port write byte
	input wire [7:0] i_io_rdata // Port read byte
);

	localparam S_IDLE = 2'h0;
	localparam S_RUN = 2'h1;
	localparam S_PMW = 2'h2;

	reg [7:0] gpr [0:31];
	reg [15:0] pc;
	reg [15:0] sp;
	reg [2:0] flags;
	reg [15:0] imm;
	reg [4:0] gsel;
	reg [1:0] state;
	reg [7:0] cnt;
	reg [7:0] need;
	reg [7:0] last;
	reg [4:0] code;
	reg [4:0] dst;
	reg [4:0] src;
	reg [1:0] ptr;
	reg [2:0] amode;
	reg [15:0] nptr;
	reg [15:0] pc_fin;

	// ------------------------------------------------------------
	// Launch decode
	// ------------------------------------------------------------
	wire acc = i_psel & i_penable & o_pready;
	wire wr_acc = acc & i_pwrite & ~o_pslverr;
	wire [4:0] l_code = i_pwdata[`CBD_F_CODE];
	wire [4:0] l_dst = i_pwdata[`CBD_F_DST];
	wire [4:0] l_src = i_pwdata[`CBD_F_SRC];
	wire [1:0] l_mode = i_pwdata[`CBD_F_MODE];
	wire l_prog = (l_code == `CBD_OP_LPM) | (l_code == `CBD_OP_SPM);
	wire [1:0] l_ptr = l_prog ? `CBD_PTR_Z : i_pwdata[`CBD_F_PTR];
	wire [15:0] l_pval = {gpr[{2'b11, l_ptr, 1'b1}], gpr[{2'b11, l_ptr, 1'b0}]};
	wire launch = wr_acc & (i_paddr == `CBD_REG_OP);
	wire [15:0] br_off = {{9{imm[6]}}, imm[6:0]};
	wire done_run = (state == S_RUN) & (cnt == need);
	wire done_pmw = (state == S_PMW) & i_pm_done;
	wire finish = done_run | done_pmw;

	reg [15:0] l_base;
	reg [2:0] l_amode;
	reg [7:0] l_need;
	reg l_taken;
	reg l_bad;
	wire [15:0] a_addr;
	wire [15:0] a_next;

	always @* begin
		l_base = l_pval;
		l_amode = {1'b0, l_mode};
		l_need = `CBD_CYC_MEM;
		l_taken = 1'b0;
		l_bad = 1'b0;
		case (l_code)
			`CBD_OP_BR_UCLR: begin
				l_taken = ~flags[`CBD_FL_USER];
			end
			`CBD_OP_BR_SCSET: begin
				l_taken = flags[`CBD_FL_SCARRY];
			end
			`CBD_OP_BR_SCCLR: begin
				l_taken = ~flags[`CBD_FL_SCARRY];
			end
			`CBD_OP_BR_MEN: begin
				l_taken = flags[`CBD_FL_MASK];
			end
			`CBD_OP_BR_MDIS: begin
				l_taken = ~flags[`CBD_FL_MASK];
			end
			`CBD_OP_COPY, `CBD_OP_PAIR, `CBD_OP_LDI, `CBD_OP_IN, `CBD_OP_OUT: begin
				l_need = `CBD_CYC_ONE;
			end
			`CBD_OP_LDIND, `CBD_OP_STIND: begin
				// Only plain, post-increment and pre-decrement exist
				l_bad = (l_ptr == 2'h0) | (l_mode == 2'h3);
			end
			`CBD_OP_LDDISP, `CBD_OP_STDISP: begin
				l_amode = `CBD_AM_DISP;
				l_bad = (l_ptr != `CBD_PTR_Y) & (l_ptr != `CBD_PTR_Z);
			end
			`CBD_OP_LDDIR, `CBD_OP_STDIR: begin
				l_base = imm;
				l_amode = `CBD_AM_PLAIN;
			end
			`CBD_OP_LPM: begin
				l_amode = {2'b00, l_mode[0]};
				l_need = `CBD_CYC_PROG;
			end
			`CBD_OP_SPM: begin
				l_amode = `CBD_AM_PLAIN;
			end
			`CBD_OP_PUSH: begin
				l_base = sp;
				l_amode = `CBD_AM_PUSH;
			end
			`CBD_OP_POP: begin
				l_base = sp;
				l_amode = `CBD_AM_POP;
			end
			default: begin
				l_bad = 1'b1;
			end
		endcase
		if (l_code <= `CBD_OP_BR_MDIS) begin
			l_need = l_taken ? `CBD_CYC_BR_TAKEN : `CBD_CYC_ONE;
		end
	end

	cbd_agen #(
		.AW(16)
	) u_agen (
		.i_base(l_base),
		.i_mode(l_amode),
		.i_disp(imm[5:0]),
		.o_addr(a_addr),
		.o_next(a_next)
	);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Registered answer: decoded in setup, shown in the access cycle
	reg [31:0] rd_mux;
	reg rd_err;

	always @* begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (i_paddr)
			`CBD_REG_OP: rd_mux = {27'h0000000, code};
			`CBD_REG_IMM: rd_mux = {16'h0000, imm};
			`CBD_REG_FLAGS: rd_mux = {29'h00000000, flags};
			`CBD_REG_PC: rd_mux = {16'h0000, pc};
			`CBD_REG_SP: rd_mux = {16'h0000, sp};
			`CBD_REG_GSEL: rd_mux = {27'h0000000, gsel};
			`CBD_REG_GDATA: rd_mux = {24'h000000, gpr[gsel]};
			`CBD_REG_STAT: rd_mux = {16'h0000, last, 7'h00, o_busy};
			default: rd_err = 1'b1;
		endcase
		// Writes while busy would race the running operation
		if (i_pwrite & (o_busy | finish)) begin
			rd_err = 1'b1;
		end
		if (i_pwrite & (i_paddr == `CBD_REG_OP) & l_bad) begin
			rd_err = 1'b1;
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else if (i_psel & ~i_penable) begin
			o_pready <= 1'b1;
			o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
			o_pslverr <= rd_err;
		end else begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sequencer and memory requests
	// ------------------------------------------------------------
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= S_IDLE;
			o_busy <= 1'b0;
			cnt <= 8'h00;
			need <= 8'h00;
			last <= 8'h00;
			code <= 5'h00;
			dst <= 5'h00;
			src <= 5'h00;
			ptr <= 2'h0;
			amode <= 3'h0;
			nptr <= 16'h0000;
			pc_fin <= 16'h0000;
			pc <= `CBD_PC_RST;
			sp <= `CBD_SP_RST;
			flags <= `CBD_FLAGS_RST;
			imm <= 16'h0000;
			gsel <= 5'h00;
			o_dm_addr <= 16'h0000;
			o_dm_re <= 1'b0;
			o_dm_we <= 1'b0;
			o_dm_wdata <= 8'h00;
			o_pm_addr <= 16'h0000;
			o_pm_re <= 1'b0;
			o_pm_we <= 1'b0;
			o_pm_wdata <= 16'h0000;
			o_io_addr <= 6'h00;
			o_io_re <= 1'b0;
			o_io_we <= 1'b0;
			o_io_wdata <= 8'h00;
		end else begin
			// Write strobes last exactly one cycle
			o_dm_we <= 1'b0;
			o_pm_we <= 1'b0;
			o_io_we <= 1'b0;
			if (wr_acc) begin
				case (i_paddr)
					`CBD_REG_IMM: imm <= i_pwdata[15:0];
					`CBD_REG_FLAGS: flags <= i_pwdata[2:0];
					`CBD_REG_PC: pc <= i_pwdata[15:0];
					`CBD_REG_SP: sp <= i_pwdata[15:0];
					`CBD_REG_GSEL: gsel <= i_pwdata[4:0];
					default: gsel <= gsel;
				endcase
			end
			case (state)
				S_IDLE: begin
					if (launch) begin
						state <= (l_code == `CBD_OP_SPM) ? S_PMW : S_RUN;
						o_busy <= 1'b1;
						cnt <= 8'h01;
						need <= l_need;
						code <= l_code;
						dst <= l_dst;
						src <= l_src;
						ptr <= l_ptr;
						amode <= l_amode;
						nptr <= a_next;
						// Branch target or next sequential word
						pc_fin <= l_taken ? (pc + br_off + 16'h0001) : (pc + 16'h0001);
						o_dm_addr <= a_addr;
						o_dm_wdata <= gpr[l_src];
						o_dm_re <= (l_code == `CBD_OP_LDIND) | (l_code == `CBD_OP_LDDISP)
							| (l_code == `CBD_OP_LDDIR) | (l_code == `CBD_OP_POP);
						o_dm_we <= (l_code == `CBD_OP_STIND) | (l_code == `CBD_OP_STDISP)
							| (l_code == `CBD_OP_STDIR) | (l_code == `CBD_OP_PUSH);
						o_pm_addr <= a_addr;
						o_pm_re <= (l_code == `CBD_OP_LPM);
						o_pm_we <= (l_code == `CBD_OP_SPM);
						o_pm_wdata <= {gpr[1], gpr[0]};
						o_io_addr <= imm[5:0];
						o_io_wdata <= gpr[l_src];
						o_io_re <= (l_code == `CBD_OP_IN);
						o_io_we <= (l_code == `CBD_OP_OUT);
					end
				end
				S_RUN, S_PMW: begin
					if (cnt != 8'hFF) begin
						cnt <= cnt + 8'h01;
					end
					if (finish) begin
						state <= S_IDLE;
						o_busy <= 1'b0;
						last <= cnt;
						pc <= pc_fin;
						o_dm_re <= 1'b0;
						o_pm_re <= 1'b0;
						o_io_re <= 1'b0;
						if ((code == `CBD_OP_PUSH) | (code == `CBD_OP_POP)) begin
							sp <= nptr;
						end
					end
				end
				default: begin
					state <= S_IDLE;
					o_busy <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file write-back
	// ------------------------------------------------------------
	// No reset: contents are data, not control
	wire ptr_upd = ((code == `CBD_OP_LDIND) | (code == `CBD_OP_STIND)
		| (code == `CBD_OP_LPM)) & ((amode == `CBD_AM_POSTINC) | (amode == `CBD_AM_PREDEC));
	wire [4:0] ptr_lo = {2'b11, ptr, 1'b0};
	wire [4:0] ptr_hi = {2'b11, ptr, 1'b1};
	wire [4:0] dpair = {dst[4:1], 1'b0};
	wire [4:0] spair = {src[4:1], 1'b0};
	wire [4:0] dpair_hi = {dst[4:1], 1'b1};
	wire [4:0] spair_hi = {src[4:1], 1'b1};

	always @(posedge i_clk) begin
		if (wr_acc & (i_paddr == `CBD_REG_GDATA)) begin
			gpr[gsel] <= i_pwdata[7:0];
		end
		if (done_run) begin
			// Pointer first, so a loaded byte wins on overlap
			if (ptr_upd) begin
				gpr[ptr_lo] <= nptr[7:0];
				gpr[ptr_hi] <= nptr[15:8];
			end
			case (code)
				`CBD_OP_COPY: begin
					gpr[dst] <= gpr[src];
				end
				`CBD_OP_PAIR: begin
					gpr[dpair] <= gpr[spair];
					gpr[dpair_hi] <= gpr[spair_hi];
				end
				`CBD_OP_LDI: begin
					gpr[dst] <= imm[7:0];
				end
				`CBD_OP_IN: begin
					gpr[dst] <= i_io_rdata;
				end
				`CBD_OP_LDIND, `CBD_OP_LDDISP, `CBD_OP_LDDIR, `CBD_OP_POP: begin
					gpr[dst] <= i_dm_rdata;
				end
				`CBD_OP_LPM: begin
					gpr[dst] <= i_pm_rdata;
				end
				default: begin
					gpr[dst] <= gpr[dst];
				end
			endcase
		end
	end

endmodule // cbd_core
`default_nettype wire

// ### cbd_map.vh
// Register map, field layout, opcodes and cycle counts of the branch/transfer core.
// Assumes a 32-bit APB with byte addresses; included by the core, the address generator and the bench.
`ifndef CBD_MAP_VH
`define CBD_MAP_VH

// APB register offsets
`define CBD_REG_OP 12'h000
`define CBD_REG_IMM 12'h004
`define CBD_REG_FLAGS 12'h008
`define CBD_REG_PC 12'h00C
`define CBD_REG_SP 12'h010
`define CBD_REG_GSEL 12'h014
`define CBD_REG_GDATA 12'h018
`define CBD_REG_STAT 12'h01C

// Fields of the operation word
`define CBD_F_CODE 4:0
`define CBD_F_DST 9:5
`define CBD_F_SRC 14:10
`define CBD_F_PTR 16:15
`define CBD_F_MODE 18:17

// Flag bit positions
`define CBD_FL_USER 0
`define CBD_FL_SCARRY 1
`define CBD_FL_MASK 2

// Reset values
`define CBD_PC_RST 16'h0000
`define CBD_SP_RST 16'h0000
`define CBD_FLAGS_RST 3'h0

// Operation codes
`define CBD_OP_BR_UCLR 5'h00
`define CBD_OP_BR_SCSET 5'h01
`define CBD_OP_BR_SCCLR 5'h02
`define CBD_OP_BR_MEN 5'h03
`define CBD_OP_BR_MDIS 5'h04
`define CBD_OP_COPY 5'h05
`define CBD_OP_PAIR 5'h06
`define CBD_OP_LDI 5'h07
`define CBD_OP_LDIND 5'h08
`define CBD_OP_LDDISP 5'h09
`define CBD_OP_LDDIR 5'h0A
`define CBD_OP_STIND 5'h0B
`define CBD_OP_STDISP 5'h0C
`define CBD_OP_STDIR 5'h0D
`define CBD_OP_LPM 5'h0E
`define CBD_OP_SPM 5'h0F
`define CBD_OP_IN 5'h10
`define CBD_OP_OUT 5'h11
`define CBD_OP_PUSH 5'h12
`define CBD_OP_POP 5'h13

// Pointer selection
`define CBD_PTR_X 2'h1
`define CBD_PTR_Y 2'h2
`define CBD_PTR_Z 2'h3

// Address generator modes
`define CBD_AM_PLAIN 3'h0
`define CBD_AM_POSTINC 3'h1
`define CBD_AM_PREDEC 3'h2
`define CBD_AM_DISP 3'h3
`define CBD_AM_PUSH 3'h4
`define CBD_AM_POP 3'h5

// Execution lengths in clock cycles
`define CBD_CYC_ONE 8'h01
`define CBD_CYC_MEM 8'h02
`define CBD_CYC_PROG 8'h03
`define CBD_CYC_BR_TAKEN 8'h02

`endif

// ### cbd_agen.v
// Address generator: effective address and updated base for one access.
// Pure combinational; the caller registers both results.
`timescale 1ns/100ps
`default_nettype none
`include "cbd_map.vh"

module cbd_agen #(
	parameter AW = 16
) (
	input wire [AW-1:0] i_base, // Pointer, stack pointer or constant
	input wire [2:0] i_mode, // Address mode
	input wire [5:0] i_disp, // Unsigned displacement
	output reg [AW-1:0] o_addr, // Address to access
	output reg [AW-1:0] o_next // Base after the access
);

	always @* begin
		o_addr = i_base;
		o_next = i_base;
		case (i_mode)
			`CBD_AM_POSTINC: begin
				o_next = i_base + 1'b1;
			end
			`CBD_AM_PREDEC: begin
				// Decrement before use, so both results agree
				o_addr = i_base - 1'b1;
				o_next = i_base - 1'b1;
			end
			`CBD_AM_DISP: begin
				o_addr = i_base + {{(AW-6){1'b0}}, i_disp};
			end
			`CBD_AM_PUSH: begin
				o_next = i_base - 1'b1;
			end
			`CBD_AM_POP: begin
				o_addr = i_base + 1'b1;
				o_next = i_base + 1'b1;
			end
			default: begin
				o_addr = i_base;
			end
		endcase
	end

endmodule // cbd_agen
`default_nettype wire

// ### cbd_mem_model.sv
// Partner model: data memory, program memory and port space.
// Assumes the core's strobes come from the same clock; reads answer at once.
`timescale 1ns/100ps
`default_nettype none
module cbd_mem_model #(
	parameter PM_WAIT = 5 // Program write length
) (
	input wire logic i_clk, // Clock
	input wire logic [15:0] i_dm_addr, // Data address
	input wire logic i_dm_re, // Data read
	input wire logic i_dm_we, // Data write
	input wire logic [7:0] i_dm_wdata, // Data byte
	output logic [7:0] o_dm_rdata, // Data read byte
	input wire logic [15:0] i_pm_addr, // Program address
	input wire logic i_pm_re, // Program read
	input wire logic i_pm_we, // Program write
	input wire logic [15:0] i_pm_wdata, // Program word
	output logic [7:0] o_pm_rdata, // Program byte
	output logic o_pm_done, // Program write done
	input wire logic [5:0] i_io_addr, // Port address
	input wire logic i_io_re, // Port read
	input wire logic i_io_we, // Port write
	input wire logic [7:0] i_io_wdata, // Port byte
	output logic [7:0] o_io_rdata // Port read byte
);
	logic [7:0] dm [0:65535];
	logic [7:0] pm [0:65535];
	logic [7:0] io [0:63];
	logic [7:0] dm_last = 8'h00, pm_last = 8'h00, io_last = 8'h00;
	int wait_n = 0;
	initial begin
		for (int a = 0; a < 65536; a++) begin
			dm[a] = a[7:0] ^ a[15:8];
			pm[a] = ~(a[7:0] ^ a[15:8]);
		end
	end
	// Deselected read lines toggle so a stale byte is never mistaken for data
	assign o_dm_rdata = i_dm_re ? dm[i_dm_addr] : ~dm_last;
	assign o_pm_rdata = i_pm_re ? pm[i_pm_addr] : ~pm_last;
	assign o_io_rdata = i_io_re ? io[i_io_addr] : ~io_last;
	always @(posedge i_clk) begin
		dm_last <= o_dm_rdata;
		pm_last <= o_pm_rdata;
		io_last <= o_io_rdata;
		o_pm_done <= (wait_n == 1);
		wait_n <= i_pm_we ? PM_WAIT : (wait_n > 0 ? wait_n - 1 : 0);
		if (i_dm_we) dm[i_dm_addr] <= i_dm_wdata;
		if (i_io_we) io[i_io_addr] <= i_io_wdata;
		if (i_pm_we) begin
			pm[{i_pm_addr[15:1], 1'b0}] <= i_pm_wdata[7:0];
			pm[{i_pm_addr[15:1], 1'b1}] <= i_pm_wdata[15:8];
		end
	end
endmodule // cbd_mem_model
`default_nettype wire

// ### cbd_core_sva.sv
// Port timing checker of the core.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cbd_core_chk (
	input wire logic i_clk, // Clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic o_pready, // APB ready
	input wire logic o_pslverr, // APB error
	input wire logic o_busy, // Busy
	input wire logic [15:0] o_dm_addr, // Data address
	input wire logic o_dm_re, // Data read
	input wire logic o_dm_we, // Data write
	input wire logic o_pm_re, // Program read
	input wire logic o_pm_we, // Program write
	input wire logic i_pm_done, // Program done
	input wire logic o_io_re, // Port read
	input wire logic o_io_we // Port write
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd_two;
		o_dm_re && o_busy ##1 o_dm_re && o_busy ##1 !o_dm_re && !o_busy;
	endsequence
	sequence s_wr_two;
		o_busy ##1 o_busy && !o_dm_we ##1 !o_busy;
	endsequence
	property p_setup_ready;
		i_psel && !i_penable |=> o_pready;
	endproperty
	property p_err_ready;
		o_pslverr |-> o_pready;
	endproperty
	property p_load_len;
		$rose(o_dm_re) |-> s_rd_two;
	endproperty
	property p_store_len;
		o_dm_we |-> s_wr_two;
	endproperty
	property p_prog_len;
		$rose(o_pm_re) |-> o_pm_re[*3] ##1 !o_pm_re && !o_busy;
	endproperty
	property p_port_rd;
		$rose(o_io_re) |-> o_busy ##1 !o_io_re && !o_busy;
	endproperty
	property p_port_wr;
		o_io_we |=> !o_io_we && !o_busy;
	endproperty
	property p_addr_hold;
		o_busy && $past(o_busy) |-> $stable(o_dm_addr);
	endproperty
	property p_pm_end;
		o_pm_we |-> o_busy ##1 !o_pm_we;
	endproperty
	property p_pm_done;
		i_pm_done && o_busy |=> !o_busy;
	endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_load_len: assert property (p_load_len) else $error("load length wrong");
	a_store_len: assert property (p_store_len) else $error("store length wrong");
	a_prog_len: assert property (p_prog_len) else $error("program read length");
	a_port_rd: assert property (p_port_rd) else $error("port read length");
	a_port_wr: assert property (p_port_wr) else $error("port write length");
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	a_pm_end: assert property (p_pm_end) else $error("program strobe length");
	a_pm_done: assert property (p_pm_done) else $error("busy after done");
endmodule // cbd_core_chk
bind cbd_core cbd_core_chk u_chk (.i_clk, .i_rst_n, .i_psel, .i_penable, .o_pready,
	.o_pslverr, .o_busy, .o_dm_addr, .o_dm_re, .o_dm_we, .o_pm_re, .o_pm_we,
	.i_pm_done, .o_io_re, .o_io_we);
`default_nettype wire

// ### test_cpu_branch_and_data_transfer.sv
// Bench: drives the core over APB, memory model on the far side.
// Assumes the map header and a one-cycle APB access.
`timescale 1ns/100ps
`default_nettype none
`include "cbd_map.vh"
module test_cpu_branch_and_data_transfer;
	logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_busy;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic [15:0] o_dm_addr, o_pm_addr, o_pm_wdata;
	logic o_dm_re, o_dm_we, o_pm_re, o_pm_we, i_pm_done, o_io_re, o_io_we;
	logic [7:0] o_dm_wdata, i_dm_rdata, i_pm_rdata, o_io_wdata, i_io_rdata;
	logic [5:0] o_io_addr;
	int n_fail = 0;
	int n_compared = 0;
	logic [32:0] exp_q[$];
	cbd_core DUT (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_pready, .o_prdata, .o_pslverr, .o_busy, .o_dm_addr, .o_dm_re, .o_dm_we,
		.o_dm_wdata, .i_dm_rdata, .o_pm_addr, .o_pm_re, .o_pm_we, .o_pm_wdata, .i_pm_rdata,
		.i_pm_done, .o_io_addr, .o_io_re, .o_io_we, .o_io_wdata, .i_io_rdata);
	cbd_mem_model u_mem (.i_clk, .i_dm_addr(o_dm_addr), .i_dm_re(o_dm_re),
		.i_dm_we(o_dm_we), .i_dm_wdata(o_dm_wdata), .o_dm_rdata(i_dm_rdata),
		.i_pm_addr(o_pm_addr), .i_pm_re(o_pm_re), .i_pm_we(o_pm_we),
		.i_pm_wdata(o_pm_wdata), .o_pm_rdata(i_pm_rdata), .o_pm_done(i_pm_done),
		.i_io_addr(o_io_addr), .i_io_re(o_io_re), .i_io_we(o_io_we),
		.i_io_wdata(o_io_wdata), .o_io_rdata(i_io_rdata));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ----
	// Bus tasks and scoreboard
	// ----
	task automatic cmp(input logic [32:0] e, input logic [32:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED apb answer exp %h got %h", e, s);
		end
	endtask
	always @(posedge i_clk) if (i_psel && i_penable && o_pready) begin
		if (exp_q.size() == 0) cmp(33'h0, 33'h1FFFFFFFF);
		else cmp(exp_q.pop_front(), {o_pslverr, o_prdata});
	end
	// Leaves select high so a following transfer can start at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		exp_q.push_back(e);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		i_penable <= 1'b0;
	endtask
	task automatic idle();
		i_psel <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic op(input logic [4:0] c, input logic [4:0] dd, input logic [4:0] ss,
		input logic [1:0] p, input logic [1:0] m, input logic [31:0] imm, input logic [7:0] n);
		xfer(1, `CBD_REG_IMM, imm, 0);
		xfer(1, `CBD_REG_OP, {13'h0, m, p, ss, dd, c}, 0);
		idle();
		for (int j = 0; j < 20 && o_busy === 1'b1; j++) @(posedge i_clk);
		// A hung operation counts as a mismatch
		if (o_busy !== 1'b0) n_fail++;
		if (n != 0) xfer(0, `CBD_REG_STAT, 0, {17'h0, n, 8'h00});
	endtask
	task automatic setr(input logic [4:0] r, input logic [7:0] v);
		xfer(1, `CBD_REG_GSEL, r, 0);
		xfer(1, `CBD_REG_GDATA, v, 0);
	endtask
	task automatic chkr(input logic [4:0] r, input logic [7:0] v);
		xfer(1, `CBD_REG_GSEL, r, 0);
		xfer(0, `CBD_REG_GDATA, 0, {25'h0, v});
	endtask
	task automatic setp(input logic [1:0] p, input logic [15:0] a);
		setr(5'h18 + {p, 1'b0}, a[7:0]);
		setr(5'h19 + {p, 1'b0}, a[15:8]);
	endtask
	task automatic chkp(input logic [1:0] p, input logic [15:0] a);
		chkr(5'h18 + {p, 1'b0}, a[7:0]);
		chkr(5'h19 + {p, 1'b0}, a[15:8]);
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200us;
		n_fail++;
		close_out();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		logic [15:0] a, e;
		logic [7:0] v, w;
		logic [6:0] k;
		logic t;
		i_rst_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		void'($urandom(32'h9923F807));
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		xfer(0, `CBD_REG_PC, 0, 0);
		xfer(0, `CBD_REG_SP, 0, 0);
		xfer(1, 12'h020, 0, 33'h100000000);
		xfer(1, 12'h006, 0, 33'h100000000);
		for (int c = 0; c < 5; c++) for (int i = 0; i < 2; i++) begin
			k = $urandom;
			a = $urandom;
			t = (c == 1 || c == 3) ? i[0] : !i[0];
			xfer(1, `CBD_REG_FLAGS, i ? 3'h7 : 3'h0, 0);
			xfer(1, `CBD_REG_PC, a, 0);
			op(c[4:0], 0, 0, 0, 0, k, t ? 2 : 1);
			e = t ? a + {{9{k[6]}}, k} + 16'h1 : a + 16'h1;
			xfer(0, `CBD_REG_PC, 0, e);
			xfer(0, `CBD_REG_FLAGS, 0, i ? 3'h7 : 3'h0);
		end
		w = $urandom;
		k = $urandom;
		op(`CBD_OP_LDI, 1, 0, 0, 0, w, 1);
		op(`CBD_OP_COPY, 4, 1, 0, 0, 0, 1);
		setr(2, ~w);
		setr(3, w);
		op(`CBD_OP_PAIR, 6, 2, 0, 0, 0, 1);
		op(`CBD_OP_OUT, 0, 4, 0, 0, k[5:0], 1);
		op(`CBD_OP_IN, 8, 0, 0, 0, k[5:0], 1);
		chkr(8, w);
		chkr(6, ~w);
		chkr(7, w);
		for (int p = 1; p < 4; p++) for (int m = 0; m < 3; m++) begin
			a = $urandom;
			v = $urandom;
			e = (m == 2) ? a - 16'h1 : a;
			setp(p[1:0], a);
			op(`CBD_OP_LDIND, 2, 0, p[1:0], m[1:0], 0, 2);
			chkr(2, e[7:0] ^ e[15:8]);
			chkp(p[1:0], m == 1 ? a + 16'h1 : e);
			setr(3, v);
			setp(p[1:0], a);
			op(`CBD_OP_STIND, 0, 3, p[1:0], m[1:0], 0, 2);
			chkp(p[1:0], m == 1 ? a + 16'h1 : e);
			op(`CBD_OP_LDDIR, 9, 0, 0, 0, e, 2);
			chkr(9, v);
		end
		for (int p = 2; p < 4; p++) begin
			a = $urandom;
			k = $urandom;
			e = a + k[5:0];
			setp(p[1:0], a);
			op(`CBD_OP_LDDISP, 2, 0, p[1:0], 0, k[5:0], 2);
			chkr(2, e[7:0] ^ e[15:8]);
			op(`CBD_OP_STDISP, 0, 1, p[1:0], 0, k[5:0], 2);
			chkp(p[1:0], a);
			op(`CBD_OP_LDDIR, 9, 0, 0, 0, e, 2);
			chkr(9, w);
		end
		a = $urandom;
		op(`CBD_OP_STDIR, 0, 4, 0, 0, a, 2);
		op(`CBD_OP_LDDIR, 9, 0, 0, 0, a, 2);
		chkr(9, w);
		// A write during a load, then bad pointers, a bad mode and an unknown code
		xfer(1, `CBD_REG_OP, {23'h0, 4'h0, `CBD_OP_LDDIR}, 0);
		xfer(1, `CBD_REG_PC, 0, 33'h100000000);
		xfer(1, `CBD_REG_OP, {15'h0, `CBD_PTR_X, 10'h0, `CBD_OP_LDDISP}, 33'h100000000);
		xfer(1, `CBD_REG_OP, {13'h0, 2'h3, `CBD_PTR_X, 10'h0, `CBD_OP_LDIND}, 33'h100000000);
		xfer(1, `CBD_REG_OP, {15'h0, 2'h0, 10'h0, `CBD_OP_STIND}, 33'h100000000);
		xfer(1, `CBD_REG_OP, {27'h0, 5'h14}, 33'h100000000);
		idle();
		a = $urandom;
		setp(3, a);
		op(`CBD_OP_LPM, 0, 0, 3, 0, 0, 3);
		chkr(0, ~(a[7:0] ^ a[15:8]));
		op(`CBD_OP_LPM, 5, 0, 3, 1, 0, 3);
		chkp(3, a + 16'h1);
		setr(0, w);
		setr(1, ~w);
		op(`CBD_OP_SPM, 0, 0, 3, 0, 0, 0);
		op(`CBD_OP_LPM, 5, 0, 3, 0, 0, 3);
		chkr(5, (a[0] ^ 1'b1) ? ~w : w);
		a = $urandom;
		v = $urandom;
		xfer(1, `CBD_REG_SP, a, 0);
		setr(10, v);
		setr(11, ~v);
		op(`CBD_OP_PUSH, 0, 10, 0, 0, 0, 2);
		op(`CBD_OP_PUSH, 0, 11, 0, 0, 0, 2);
		e = a - 16'h2;
		xfer(0, `CBD_REG_SP, 0, e);
		op(`CBD_OP_POP, 12, 0, 0, 0, 0, 2);
		op(`CBD_OP_POP, 13, 0, 0, 0, 0, 2);
		chkr(12, ~v);
		chkr(13, v);
		xfer(0, `CBD_REG_SP, 0, a);
		idle();
		close_out();
	end
endmodule // test_cpu_branch_and_data_transfer
`default_nettype wire
